// ==== hw/osrl_pkg.sv ====
// Constants, register map and carrier types of the octal supply reset logic
package osrl_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_PERIOD_PS        = 50000;
	// Nominal comparator-to-output filter time
	localparam int FILTER_TIME_NS       = 125000;
	localparam int FILTER_CYCLES        = (FILTER_TIME_NS * 1000) / CLK_PERIOD_PS;
	// Release delay: 8.5 ms for the 1 nF setting (about 8.5 ms/nF)
	localparam int RELEASE_DELAY_US     = 8500;
	localparam int RELEASE_DELAY_CYCLES = (RELEASE_DELAY_US * 1000) / (CLK_PERIOD_PS / 1000);

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int NUM_CH    = 8;
	localparam int FILT_W    = 12;
	localparam int DELAY_W   = 24;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int NUM_IRQ   = 3;
	localparam logic [FILT_W-1:0] FILT_LIMIT = FILT_W'(FILTER_CYCLES);
	localparam logic [FILT_W-1:0] FILT_ZERO  = 12'h000;
	localparam logic [DELAY_W-1:0] DELAY_ONE = 24'h00_0001;
	localparam logic [DELAY_W-1:0] DELAY_ZERO = 24'h00_0000;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [ADDR_W-1:0] ADDR_DELAY_TC = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0C;

	// Status register fields
	localparam int ST_FAULT_LSB  = 0;
	localparam int ST_STATE_LSB  = 8;
	localparam int ST_RST_HI     = 10;
	localparam int ST_LOCKOUT    = 11;
	localparam int ST_QUIET      = 12;
	localparam int ST_POL_LSB    = 13;

	// Interrupt bits: reset asserted, reset released, filtered fault change
	localparam int IRQ_ASSERT  = 0;
	localparam int IRQ_RELEASE = 1;
	localparam int IRQ_FAULT   = 2;
	localparam logic [NUM_IRQ-1:0] IRQ_RESET_VAL = 3'h0;
	localparam logic [DATA_W-1:0]  DATA_ZERO     = 32'h0000_0000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0]
	{
		ST_HOLD    = 2'b00,
		ST_TIMING  = 2'b01,
		ST_RELEASE = 2'b11
	} osrl_state_type;

	typedef struct packed
	{
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} osrl_apb_req_type;

	typedef struct packed
	{
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} osrl_apb_rsp_type;

endpackage : osrl_pkg

// ==== hw/osrl_top.sv ====
// Reset generation logic of the octal supply supervisor with APB registers
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module osrl_top
	import osrl_pkg::*;
#(
	parameter logic [DELAY_W-1:0] RELEASE_TC = DELAY_W'(RELEASE_DELAY_CYCLES)
)
(
	input  wire logic             CLK_SYS,
	input  wire logic             RESET,
	input  wire osrl_apb_req_type APB_REQ,
	output osrl_apb_rsp_type      APB_RSP,
	input  wire logic [7:0]       CMP_BELOW,
	input  wire logic             SEL_HIGH,
	input  wire logic             SEL_LOW,
	input  wire logic             OUTPUT_QUIET_IN,
	input  wire logic             DELAY_TIMER_PIN_TIED,
	input  wire logic             SUPPLY_LOCKOUT,
	output logic                  RST_HI_O,
	output logic                  RST_HI_OE_N,
	output logic                  RST_LO_N_O,
	output logic                  RST_LO_N_OE_N,
	output logic                  IRQ
);

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic [FILT_W-1:0] filt_step(input logic [FILT_W-1:0] cnt, input logic raw);
		logic [FILT_W-1:0] res;
		res = cnt;
		if (raw && cnt != FILT_LIMIT)
			res = cnt + 1'b1;
		else if (!raw && cnt != FILT_ZERO)
			res = cnt - 1'b1;
		return res;
	endfunction : filt_step

	// ************************************************************
	// Polarity decode and raw channel faults
	// ************************************************************
	logic [1:0]              pos_78;
	logic [NUM_CH-1:0]       raw_fault;
	logic [NUM_CH-1:0]       flt_q;
	logic [FILT_W-1:0]       filt_q [NUM_CH];
	osrl_state_type          st_q;
	logic [DELAY_W-1:0]      cnt_q;
	logic [DELAY_W-1:0]      delay_tc_q;
	logic                    any_fault;
	logic                    assert_d;
	logic [NUM_IRQ-1:0]      irq_stat_q;
	logic [NUM_IRQ-1:0]      irq_mask_q;
	logic [NUM_IRQ-1:0]      irq_evt;

	always_comb
	begin
		if (SEL_HIGH)
			pos_78 = 2'b11;
		else if (SEL_LOW)
			pos_78 = 2'b00;
		else
			pos_78 = 2'b01;
		raw_fault[5:0] = CMP_BELOW[5:0];
		raw_fault[6] = pos_78[0] ? CMP_BELOW[6] : !CMP_BELOW[6];
		raw_fault[7] = pos_78[1] ? CMP_BELOW[7] : !CMP_BELOW[7];
	end

	// ************************************************************
	// Glitch integrators
	// ************************************************************
	// integrate each decision
	always_ff @(posedge CLK_SYS)
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (RESET)
				filt_q[i] <= FILT_ZERO;
			else
				filt_q[i] <= filt_step(filt_q[i], raw_fault[i]);
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			flt_q <= '0;
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				if (filt_q[i] == FILT_LIMIT)
					flt_q[i] <= 1'b1;
				else if (filt_q[i] == FILT_ZERO)
					flt_q[i] <= 1'b0;
			end
		end
	end

	assign any_fault = |flt_q;

	// ************************************************************
	// Release sequencer
	// ************************************************************
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			st_q  <= ST_HOLD;
			cnt_q <= DELAY_ZERO;
		end
		else
		begin
			case (st_q)
				ST_HOLD:
				begin
					cnt_q <= DELAY_ZERO;
					if (!any_fault && !SUPPLY_LOCKOUT)
						st_q <= DELAY_TIMER_PIN_TIED ? ST_RELEASE : ST_TIMING;
				end
				ST_TIMING:
				begin
					if (any_fault || SUPPLY_LOCKOUT)
					begin
						st_q  <= ST_HOLD;
						cnt_q <= DELAY_ZERO;
					end
					else if (cnt_q + DELAY_ONE >= delay_tc_q)
						st_q <= ST_RELEASE;
					else
						cnt_q <= cnt_q + DELAY_ONE;
				end
				ST_RELEASE:
				begin
					cnt_q <= DELAY_ZERO;
					if (any_fault || SUPPLY_LOCKOUT)
						st_q <= ST_HOLD;
				end
				default:
				begin
					st_q  <= ST_HOLD;
					cnt_q <= DELAY_ZERO;
				end
			endcase
		end
	end

	// ************************************************************
	// Reset outputs
	// ************************************************************
	// lockout wins; quiet masks channel faults; no delay after lockout when quiet
	assign assert_d = SUPPLY_LOCKOUT || (!OUTPUT_QUIET_IN && st_q != ST_RELEASE);

	// asserted from reset onward; complementary pair
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			RST_HI_O      <= 1'b1;
			RST_HI_OE_N   <= 1'b1;
			RST_LO_N_O    <= 1'b0;
			RST_LO_N_OE_N <= 1'b0;
		end
		else
		begin
			// Open drain: strong pull-down only, high level from weak pull-up
			RST_HI_O      <= assert_d;
			RST_HI_OE_N   <= assert_d;
			RST_LO_N_O    <= !assert_d;
			RST_LO_N_OE_N <= !assert_d;
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	logic [NUM_CH-1:0] flt_prev_q;
	logic              fault_chg;

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			flt_prev_q <= '0;
		else
			flt_prev_q <= flt_q;
	end

	assign fault_chg = flt_prev_q != flt_q;

	assign irq_evt[IRQ_ASSERT]  = assert_d && !RST_HI_O;
	assign irq_evt[IRQ_RELEASE] = !assert_d && RST_HI_O;
	assign irq_evt[IRQ_FAULT]   = fault_chg;

	// ************************************************************
	// APB slave
	// ************************************************************
	logic        acc;
	logic        map_hit;
	logic [DATA_W-1:0] rd_mux;

	assign acc = APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready;

	always_comb
	begin
		map_hit = 1'b1;
		rd_mux  = DATA_ZERO;
		case (APB_REQ.paddr)
			ADDR_DELAY_TC: rd_mux[DELAY_W-1:0] = delay_tc_q;
			ADDR_STATUS:
			begin
				rd_mux[ST_FAULT_LSB +: NUM_CH] = flt_q;
				rd_mux[ST_STATE_LSB +: 2]      = st_q;
				rd_mux[ST_RST_HI]              = RST_HI_O;
				rd_mux[ST_LOCKOUT]             = SUPPLY_LOCKOUT;
				rd_mux[ST_QUIET]               = OUTPUT_QUIET_IN;
				rd_mux[ST_POL_LSB +: 2]        = pos_78;
			end
			ADDR_IRQ_STAT: rd_mux[NUM_IRQ-1:0] = irq_stat_q;
			ADDR_IRQ_MASK: rd_mux[NUM_IRQ-1:0] = irq_mask_q;
			default:       map_hit = 1'b0;
		endcase
	end

	// One wait state: answer in the second access cycle
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			APB_RSP <= '0;
		else
		begin
			APB_RSP.pready  <= acc;
			APB_RSP.pslverr <= acc && !map_hit;
			APB_RSP.prdata  <= (acc && !APB_REQ.pwrite) ? rd_mux : DATA_ZERO;
		end
	end

	logic wr_take;
	assign wr_take = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready && APB_REQ.pwrite;

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			delay_tc_q <= RELEASE_TC;
		else if (wr_take && APB_REQ.paddr == ADDR_DELAY_TC)
			delay_tc_q <= APB_REQ.pwdata[DELAY_W-1:0];
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			irq_mask_q <= IRQ_RESET_VAL;
		else if (wr_take && APB_REQ.paddr == ADDR_IRQ_MASK)
			irq_mask_q <= APB_REQ.pwdata[NUM_IRQ-1:0];
	end

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			irq_stat_q <= IRQ_RESET_VAL;
		else if (wr_take && APB_REQ.paddr == ADDR_IRQ_STAT)
			irq_stat_q <= (irq_stat_q & ~APB_REQ.pwdata[NUM_IRQ-1:0]) | irq_evt;
		else
			irq_stat_q <= irq_stat_q | irq_evt;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			IRQ <= 1'b0;
		else
			IRQ <= |(irq_stat_q & irq_mask_q);
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_lock_exit;
		SUPPLY_LOCKOUT ##1 !SUPPLY_LOCKOUT;
	endsequence

	sequence s_start_timing;
		st_q == ST_HOLD && !any_fault && !SUPPLY_LOCKOUT && !DELAY_TIMER_PIN_TIED;
	endsequence

	AST_QUIET_DEASSERT: assert property (@(posedge CLK_SYS) disable iff (RESET)
		OUTPUT_QUIET_IN && !SUPPLY_LOCKOUT |=> !RST_HI_O && RST_HI_OE_N == 1'b0)
		else $error("quiet input did not keep reset deasserted");

	AST_FAULT_ASSERT: assert property (@(posedge CLK_SYS) disable iff (RESET)
		any_fault && !OUTPUT_QUIET_IN |-> ##2 (RST_HI_O || $past(OUTPUT_QUIET_IN)))
		else $error("filtered fault did not assert reset");

	AST_DELAY_HOLD: assert property (@(posedge CLK_SYS) disable iff (RESET)
		$rose(st_q == ST_RELEASE) |-> $past(cnt_q + DELAY_ONE >= delay_tc_q) || $past(DELAY_TIMER_PIN_TIED))
		else $error("release reached before delay count");

	AST_COMPLEMENT: assert property (@(posedge CLK_SYS) disable iff (RESET)
		RST_LO_N_O == !RST_HI_O && RST_LO_N_OE_N == !RST_HI_O)
		else $error("reset pair not complementary");

	AST_SEL_DECODE: assert property (@(posedge CLK_SYS) disable iff (RESET)
		pos_78 == (SEL_HIGH ? 2'b11 : (SEL_LOW ? 2'b00 : 2'b01)))
		else $error("polarity select decoded wrongly");

	AST_BYPASS: assert property (@(posedge CLK_SYS) disable iff (RESET)
		st_q == ST_HOLD && !any_fault && !SUPPLY_LOCKOUT && DELAY_TIMER_PIN_TIED |=> st_q == ST_RELEASE)
		else $error("tied timer pin did not bypass delay");

	AST_LOCKOUT: assert property (@(posedge CLK_SYS) disable iff (RESET)
		SUPPLY_LOCKOUT |=> RST_HI_O && !RST_LO_N_O)
		else $error("lockout did not assert both outputs");

	AST_TIMER_START: assert property (@(posedge CLK_SYS) disable iff (RESET)
		s_start_timing |=> st_q == ST_TIMING && cnt_q == DELAY_ZERO)
		else $error("timer did not start from zero");

	AST_FILTER_LIMIT: assert property (@(posedge CLK_SYS) disable iff (RESET)
		$rose(flt_q[0]) |-> $past(filt_q[0]) == FILT_LIMIT)
		else $error("fault flag rose before integrator limit");

	AST_TIMER_CLEAR: assert property (@(posedge CLK_SYS) disable iff (RESET)
		st_q == ST_TIMING && any_fault |=> st_q == ST_HOLD && cnt_q == DELAY_ZERO)
		else $error("fault during timing did not clear timer");

	AST_QUIET_LOCK_EXIT: assert property (@(posedge CLK_SYS) disable iff (RESET)
		OUTPUT_QUIET_IN throughout s_lock_exit |=> !RST_HI_O)
		else $error("quiet lockout exit applied delay");

endmodule : osrl_top

// ==== testbench/osrl_sys_model.sv ====
// Far-side system logic that resolves the two open-drain reset pins
`timescale 1ns/1ps
module osrl_sys_model
(
	input  wire logic hi_oe_n,
	input  wire logic lo_oe_n,
	output logic      rst_pin,
	output logic      rst_n_pin
);
	// Weak pull-ups: a released pin reads high, never the last driven value
	assign rst_pin   = hi_oe_n ? 1'b1 : 1'b0;
	assign rst_n_pin = lo_oe_n ? 1'b1 : 1'b0;
endmodule : osrl_sys_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the octal supply reset logic
`timescale 1ns/1ps
module tb_top
	import osrl_pkg::*;
;
	// ****************
	// Environment
	// ****************
	localparam int TCI = 20;
	localparam int FW  = FILTER_CYCLES + 1;
	logic             clk_sys = 1'b0;
	logic             reset   = 1'b1;
	osrl_apb_req_type apb_req = '0;
	osrl_apb_rsp_type apb_rsp;
	logic [7:0]       cmp_below = 8'h00;
	logic             sel_high = 1'b1;
	logic             sel_low  = 1'b0;
	logic             quiet    = 1'b0;
	logic             tied     = 1'b0;
	logic             lockout  = 1'b0;
	logic             rst_hi_o, rst_hi_oe_n, rst_lo_n_o, rst_lo_n_oe_n, irq, rst_pin, rst_n_pin;
	logic [31:0]      rd;
	logic             err;
	logic [7:0]       val;
	int               failures = 0;
	int               checks_done = 0;

	always #25 clk_sys = ~clk_sys;

	osrl_top #(.RELEASE_TC(DELAY_W'(TCI))) i_osrl_top
	(
		.CLK_SYS(clk_sys), .RESET(reset), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
		.CMP_BELOW(cmp_below), .SEL_HIGH(sel_high), .SEL_LOW(sel_low),
		.OUTPUT_QUIET_IN(quiet), .DELAY_TIMER_PIN_TIED(tied), .SUPPLY_LOCKOUT(lockout),
		.RST_HI_O(rst_hi_o), .RST_HI_OE_N(rst_hi_oe_n), .RST_LO_N_O(rst_lo_n_o),
		.RST_LO_N_OE_N(rst_lo_n_oe_n), .IRQ(irq)
	);
	osrl_sys_model i_osrl_sys_model
	(
		.hi_oe_n(rst_hi_oe_n), .lo_oe_n(rst_lo_n_oe_n), .rst_pin(rst_pin), .rst_n_pin(rst_n_pin)
	);

	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (apb_rsp.pready !== 1'b1 && n < 50);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge clk_sys);
		chk(32'(n < 50), 32'h1);
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
		chk(32'(err), 32'(xe));
	endtask : rdc

	// Both pins and both raw outputs, always complementary
	task automatic exp_rst(input logic v);
		chk(32'({rst_pin, rst_n_pin, rst_hi_o, rst_lo_n_o}), 32'({v, ~v, v, ~v}));
	endtask : exp_rst

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// Sized for about 70k cycles of tests
	initial
	begin
		cyc(95000);
		failures++;
		tally_and_finish();
	end

	initial
	begin
		cyc(6);
		reset <= 1'b0;
		cyc(1);
		exp_rst(1'b1);
		rdc(ADDR_DELAY_TC, 32'(TCI), 1'b0);
		rdc(ADDR_IRQ_MASK, 32'h0, 1'b0);
		rdc(8'h10, 32'h0, 1'b1);
		apb(1'b1, ADDR_IRQ_MASK, 32'h2);
		cyc(30);
		exp_rst(1'b0);
		chk(32'(irq), 32'h1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h2);
		cyc(2);
		chk(32'(irq), 32'h0);
		$display("test 1 done");
		// Short glitch must be swallowed by the integrator
		cmp_below <= 8'h04;
		cyc(100);
		cmp_below <= 8'h00;
		cyc(FW + 40);
		exp_rst(1'b0);
		rdc(ADDR_STATUS, 32'h0000_6300, 1'b0);
		$display("test 2 done");
		cmp_below <= 8'h20;
		cyc(FW + 3);
		exp_rst(1'b1);
		cmp_below <= 8'h00;
		cyc(FW + 16);
		exp_rst(1'b1);
		cyc(10);
		exp_rst(1'b0);
		// Long delay so a fault can land mid-count
		apb(1'b1, ADDR_DELAY_TC, 32'h0000_1770);
		rdc(ADDR_DELAY_TC, 32'h0000_1770, 1'b0);
		cmp_below <= 8'h01;
		cyc(FW + 3);
		cmp_below <= 8'h00;
		cyc(FW + 2000);
		cmp_below <= 8'h01;
		cyc(FW + 3);
		exp_rst(1'b1);
		cmp_below <= 8'h00;
		cyc(FW + 5900);
		exp_rst(1'b1);
		cyc(110);
		exp_rst(1'b0);
		apb(1'b1, ADDR_DELAY_TC, 32'(TCI));
		$display("test 3 done");
		tied <= 1'b1;
		cmp_below <= 8'h01;
		cyc(FW + 3);
		exp_rst(1'b1);
		cmp_below <= 8'h00;
		cyc(FW + 4);
		exp_rst(1'b0);
		tied <= 1'b0;
		$display("test 4 done");
		for (int m = 0; m < 3; m++)
		begin
			sel_high <= (m == 0);
			sel_low <= (m == 2);
			val = (m == 0) ? 8'h00 : ((m == 1) ? 8'h80 : 8'hc0);
			cmp_below <= val;
			cyc(FW + 40);
			exp_rst(1'b0);
			cmp_below <= val ^ 8'h80;
			cyc(FW + 3);
			exp_rst(1'b1);
			cmp_below <= val;
			cyc(FW + 40);
			cmp_below <= val ^ 8'h40;
			cyc(FW + 3);
			exp_rst(1'b1);
		end
		sel_high <= 1'b1;
		sel_low <= 1'b0;
		cmp_below <= 8'h00;
		cyc(FW + 40);
		$display("test 5 done");
		quiet <= 1'b1;
		cmp_below <= 8'h02;
		cyc(FW + 5);
		exp_rst(1'b0);
		lockout <= 1'b1;
		cyc(3);
		exp_rst(1'b1);
		lockout <= 1'b0;
		cyc(3);
		exp_rst(1'b0);
		quiet <= 1'b0;
		cyc(3);
		exp_rst(1'b1);
		cmp_below <= 8'h00;
		cyc(FW + 40);
		lockout <= 1'b1;
		cyc(3);
		exp_rst(1'b1);
		lockout <= 1'b0;
		cyc(10);
		exp_rst(1'b1);
		cyc(20);
		exp_rst(1'b0);
		$display("test 6 done");
		tally_and_finish();
	end
endmodule : tb_top
